// ### rtl/sec_access_state.sv
// Security session state, access checks and write control of the tag
`default_nettype none
module sec_access_state
	import sec_access_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Command from frame decoder, one-cycle strobe
	input wire logic i_cmd_valid,
	input wire logic [2:0] i_cmd_op,
	input wire logic i_cmd_cfg,
	input wire logic [1:0] i_cmd_zone,
	input wire logic [1:0] i_cmd_set,
	input wire logic i_cmd_pw_wr,
	input wire logic [23:0] i_cmd_pw,
	input wire logic [7:0] i_cmd_len,
	input wire logic i_auth_ok,
	input wire logic i_mac_present,
	input wire logic i_mac_ok,
	// Configuration memory fields
	input wire logic [23:0] i_pw_ref,
	input wire logic [3:0] i_zone_need_rpw,
	input wire logic [3:0] i_zone_need_wpw,
	input wire logic [3:0] i_zone_need_auth,
	input wire logic [3:0] i_zone_need_enc,
	input wire logic [7:0] i_zone_set,
	input wire logic i_tear_en,
	input wire logic i_perso_secure,
	// NVM interface
	input wire logic i_tear_pending,
	input wire logic i_nvm_done,
	output logic o_nvm_req,
	output logic o_nvm_to_buf,
	output logic o_wr_cfg,
	output logic [1:0] o_wr_zone,
	// Answers and status
	output logic o_ready,
	output logic o_ack,
	output logic o_nak,
	output logic o_auth_active,
	output logic o_enc_active,
	output logic o_pw_cipher,
	output logic o_data_cipher,
	output logic o_cfg_open,
	output logic o_perso_cipher
);
	// **********************************************
	// Reset synchroniser
	// **********************************************
	logic rst_s1_q; // First stage, read only by second
	logic rst_s2_q; // Released reset for the block

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	// **********************************************
	// Access decode
	// **********************************************
	// Zone field of one zone
	function automatic logic zbit(input logic [3:0] v, input logic [1:0] z);
		zbit = v[z];
	endfunction : zbit

	// Password set index for a zone
	function automatic logic [1:0] zset(input logic [7:0] v, input logic [1:0] z);
		zset = v[{z, 1'b0} +: 2];
	endfunction : zset

	logic pw_valid_q, pw_valid_d; // A password is active
	logic pw_wr_q, pw_wr_d; // Active one is a write password
	logic [1:0] pw_set_q, pw_set_d; // Its set
	logic cfg_q, cfg_d; // Transport credential active
	logic auth_q, auth_d; // Authenticated
	logic enc_q, enc_d; // Encrypted
	logic ack_q, ack_d;
	logic nak_q, nak_d;
	logic wcfg_q, wcfg_d;
	logic [1:0] wzone_q, wzone_d;
	logic wr_start;
	logic wr_busy;
	logic wr_done;
	logic [ATT_NUM-1:0] att_fail;
	logic [ATT_NUM-1:0] att_pass;
	logic [ATT_NUM-1:0] att_lock;
	logic take;
	logic pw_ok;
	logic rd_ok;
	logic wr_ok;
	logic mac_bad;
	logic crypto_fail;
	logic [3:0] pw_idx;
	logic [3:0] key_idx;

	assign take = i_cmd_valid && o_ready;
	// Counter slots for this command
	assign pw_idx = {1'b0, i_cmd_set, i_cmd_pw_wr};
	assign key_idx = ATT_KEY_BASE + {2'h0, i_cmd_set};

	// Zone password check; write password also opens reads
	always_comb begin
		pw_ok = pw_valid_q && !cfg_q && (pw_set_q == zset(i_zone_set, i_cmd_zone));
	end

	// Read and write permission
	always_comb begin
		if (i_cmd_cfg) begin
			rd_ok = cfg_q;
			wr_ok = cfg_q;
		end else begin
			// All-zero configuration leaves zones open
			rd_ok = (!zbit(i_zone_need_rpw, i_cmd_zone) || pw_ok)
				&& (!zbit(i_zone_need_auth, i_cmd_zone) || auth_q)
				&& (!zbit(i_zone_need_enc, i_cmd_zone) || enc_q);
			wr_ok = (!zbit(i_zone_need_wpw, i_cmd_zone) || (pw_ok && pw_wr_q))
				&& (!zbit(i_zone_need_auth, i_cmd_zone) || auth_q)
				&& (!zbit(i_zone_need_enc, i_cmd_zone) || enc_q);
		end
	end

	// Checksum: plain mode rejects bad frame only
	always_comb begin
		mac_bad = i_mac_present && !i_mac_ok;
		crypto_fail = auth_q && (mac_bad || (i_cmd_op == CMD_WRITE && !i_mac_present));
	end

	// **********************************************
	// Session state
	// **********************************************
	// Next session state and answers
	always_comb begin
		pw_valid_d = pw_valid_q;
		pw_wr_d = pw_wr_q;
		pw_set_d = pw_set_q;
		cfg_d = cfg_q;
		auth_d = auth_q;
		enc_d = enc_q;
		ack_d = wr_done;
		nak_d = 1'b0;
		wcfg_d = wcfg_q;
		wzone_d = wzone_q;
		wr_start = 1'b0;
		att_fail = '0;
		att_pass = '0;
		if (take) begin
			if (crypto_fail) begin
				// Abort and drop to plain mode
				nak_d = 1'b1;
				auth_d = 1'b0;
				enc_d = 1'b0;
			end else if (mac_bad) begin
				nak_d = 1'b1;
			end else begin
				case (cmd_e'(i_cmd_op))
					CMD_READ: begin
						ack_d = rd_ok;
						nak_d = !rd_ok;
					end
					CMD_WRITE: begin
						// Page limit while buffered; checked before buffering
						if (wr_ok && !(i_tear_en && i_cmd_len > TEAR_PAGE_MAX)) begin
							wr_start = 1'b1;
							wcfg_d = i_cmd_cfg;
							wzone_d = i_cmd_zone;
						end else begin
							nak_d = 1'b1;
						end
					end
					CMD_CHKPW: begin
						// New password replaces the old one
						pw_valid_d = 1'b0;
						cfg_d = 1'b0;
						if (i_cmd_pw == TRANSPORT_PW) begin
							cfg_d = 1'b1;
							ack_d = 1'b1;
						end else if (!att_lock[pw_idx] && i_cmd_pw == i_pw_ref) begin
							pw_valid_d = 1'b1;
							pw_wr_d = i_cmd_pw_wr;
							pw_set_d = i_cmd_set;
							att_pass[pw_idx] = 1'b1;
							ack_d = 1'b1;
						end else begin
							att_fail[pw_idx] = 1'b1;
							nak_d = 1'b1;
						end
					end
					CMD_AUTH: begin
						// Only the latest outcome counts
						auth_d = i_auth_ok && !att_lock[key_idx];
						enc_d = 1'b0;
						att_pass[key_idx] = auth_d;
						att_fail[key_idx] = !auth_d;
						ack_d = auth_d;
						nak_d = !auth_d;
					end
					CMD_ENC: begin
						// Needs a live authentication
						enc_d = auth_q && i_auth_ok && !att_lock[key_idx];
						att_pass[key_idx] = enc_d;
						att_fail[key_idx] = !enc_d;
						ack_d = enc_d;
						nak_d = !enc_d;
					end
					CMD_DESEL, CMD_IDLE: begin
						// Session ends
						pw_valid_d = 1'b0;
						cfg_d = 1'b0;
						auth_d = 1'b0;
						enc_d = 1'b0;
						ack_d = 1'b1;
					end
					default: begin
						nak_d = 1'b1;
					end
				endcase
			end
		end
	end

	// Register; power-on reset clears session
	always_ff @(posedge i_mclk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			pw_valid_q <= 1'b0;
			pw_wr_q <= 1'b0;
			pw_set_q <= 2'h0;
			cfg_q <= 1'b0;
			auth_q <= 1'b0;
			enc_q <= 1'b0;
			ack_q <= 1'b0;
			nak_q <= 1'b0;
			wcfg_q <= 1'b0;
			wzone_q <= 2'h0;
		end else begin
			pw_valid_q <= pw_valid_d;
			pw_wr_q <= pw_wr_d;
			pw_set_q <= pw_set_d;
			cfg_q <= cfg_d;
			auth_q <= auth_d;
			enc_q <= enc_d;
			ack_q <= ack_d;
			nak_q <= nak_d;
			wcfg_q <= wcfg_d;
			wzone_q <= wzone_d;
		end
	end

	// **********************************************
	// Sub-blocks
	// **********************************************
	// Write sequencer, recovers torn copy first
	tear_writer u_wr (
		.i_mclk(i_mclk),
		.i_rst_b(rst_s2_q),
		.i_start(wr_start),
		.i_tear_en(i_tear_en),
		.i_pending(i_tear_pending),
		.i_nvm_done(i_nvm_done),
		.o_nvm_req(o_nvm_req),
		.o_nvm_to_buf(o_nvm_to_buf),
		.o_busy(wr_busy),
		.o_done(wr_done)
	);

	// Attempt counters
	attempt_bank u_att (
		.i_mclk(i_mclk),
		.i_rst_b(rst_s2_q),
		.i_fail(att_fail),
		.i_pass(att_pass),
		.o_locked(att_lock)
	);

	// **********************************************
	// Outputs
	// **********************************************
	assign o_ready = rst_s2_q && !wr_busy;
	assign o_ack = ack_q;
	assign o_nak = nak_q;
	assign o_wr_cfg = wcfg_q;
	assign o_wr_zone = wzone_q;
	assign o_auth_active = auth_q;
	assign o_enc_active = enc_q;
	assign o_pw_cipher = auth_q;
	assign o_data_cipher = enc_q;
	assign o_cfg_open = cfg_q;
	assign o_perso_cipher = cfg_q && i_perso_secure && enc_q;
endmodule : sec_access_state
`default_nettype wire

// ### rtl/sec_access_pkg.sv
// Shared constants and types for the secure memory access state block
`default_nettype none
package sec_access_pkg;
	// Fixed transport credential that opens configuration memory
	localparam logic [23:0] TRANSPORT_PW = 24'h30_1dd2;
	// Largest write while anti-tearing is on, in bytes
	localparam logic [7:0] TEAR_PAGE_MAX = 8'h08;
	// Failed tries before a password or key locks
	localparam logic [2:0] ATT_LIMIT = 3'h7;
	// Counter reset value
	localparam logic [2:0] ATT_RST = 3'h0;
	// Counters: 8 passwords (set*2+write) then 4 keys
	localparam int ATT_NUM = 12;
	localparam logic [3:0] ATT_KEY_BASE = 4'h8;
	// Command codes from the frame decoder
	typedef enum logic [2:0] {
		CMD_READ = 3'h0,
		CMD_WRITE = 3'h1,
		CMD_CHKPW = 3'h2,
		CMD_AUTH = 3'h3,
		CMD_ENC = 3'h4,
		CMD_DESEL = 3'h5,
		CMD_IDLE = 3'h6,
		CMD_NOP = 3'h7
	} cmd_e;
	// Write sequencer states, Gray along idle-buffer-copy-done
	typedef enum logic [1:0] {
		WR_IDLE = 2'h0,
		WR_BUF = 2'h1,
		WR_COPY = 2'h3,
		WR_DONE = 2'h2
	} wr_state_e;
endpackage : sec_access_pkg
`default_nettype wire

// ### rtl/attempt_bank.sv
// Bank of saturating failed-attempt counters for passwords and keys
`default_nettype none
module attempt_bank
	import sec_access_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic [ATT_NUM-1:0] i_fail,
	input wire logic [ATT_NUM-1:0] i_pass,
	output logic [ATT_NUM-1:0] o_locked
);
	// **********************************************
	// Counters
	// **********************************************
	logic [2:0] cnt_q [ATT_NUM];
	logic [2:0] cnt_d [ATT_NUM];

	genvar g;
	generate
		for (g = 0; g < ATT_NUM; g++) begin : g_cnt
			// Next count: success below the limit clears, failure climbs to the limit
			always_comb begin
				cnt_d[g] = cnt_q[g];
				if (i_fail[g] && cnt_q[g] != ATT_LIMIT) begin
					cnt_d[g] = cnt_q[g] + 3'h1;
				end else if (i_pass[g] && cnt_q[g] != ATT_LIMIT) begin
					cnt_d[g] = ATT_RST;
				end
			end
			// Register
			always_ff @(posedge i_mclk or negedge i_rst_b) begin
				if (!i_rst_b) begin
					cnt_q[g] <= ATT_RST;
				end else begin
					cnt_q[g] <= cnt_d[g];
				end
			end
			// Locked once the limit is reached
			assign o_locked[g] = (cnt_q[g] == ATT_LIMIT);
		end
	endgenerate
endmodule : attempt_bank
`default_nettype wire

// ### rtl/tear_writer.sv
// Write sequencer with optional anti-tearing buffer and power-up recovery
`default_nettype none
module tear_writer
	import sec_access_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_start,
	input wire logic i_tear_en,
	input wire logic i_pending,
	input wire logic i_nvm_done,
	output logic o_nvm_req,
	output logic o_nvm_to_buf,
	output logic o_busy,
	output logic o_done
);
	// **********************************************
	// State
	// **********************************************
	wr_state_e st_q, st_d;
	logic boot_q, boot_d; // Power-up check still owed
	logic tear_q, tear_d; // Current write uses the buffer

	// Next state
	always_comb begin
		st_d = st_q;
		boot_d = 1'b0;
		tear_d = tear_q;
		case (st_q)
			WR_IDLE: begin
				if (boot_q) begin
					// Interrupted copy found: redo it from buffer
					if (i_pending) begin
						st_d = WR_COPY;
						tear_d = 1'b1;
					end
				end else if (i_start) begin
					tear_d = i_tear_en;
					st_d = i_tear_en ? WR_BUF : WR_COPY;
				end
			end
			WR_BUF: begin
				// Buffer first, then a second cycle to target
				if (i_nvm_done) begin
					st_d = WR_COPY;
				end
			end
			WR_COPY: begin
				if (i_nvm_done) begin
					st_d = WR_DONE;
				end
			end
			WR_DONE: begin
				st_d = WR_IDLE;
			end
			default: begin
				st_d = WR_IDLE;
			end
		endcase
	end

	// Register
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q <= WR_IDLE;
			boot_q <= 1'b1;
			tear_q <= 1'b0;
		end else begin
			st_q <= st_d;
			boot_q <= boot_d;
			tear_q <= tear_d;
		end
	end

	// Outputs
	assign o_nvm_req = (st_q == WR_BUF) || (st_q == WR_COPY);
	assign o_nvm_to_buf = (st_q == WR_BUF);
	assign o_busy = (st_q != WR_IDLE) || boot_q;
	assign o_done = (st_q == WR_DONE);
endmodule : tear_writer
`default_nettype wire

// ### verification/sec_access_state_checker.sv
// Port-level assertions for the secure memory access state block
`default_nettype none
module sec_access_state_checker
	import sec_access_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_cmd_valid,
	input wire logic [2:0] i_cmd_op,
	input wire logic i_cmd_cfg,
	input wire logic [1:0] i_cmd_zone,
	input wire logic [7:0] i_cmd_len,
	input wire logic i_auth_ok,
	input wire logic i_mac_present,
	input wire logic i_mac_ok,
	input wire logic [3:0] i_zone_need_enc,
	input wire logic i_tear_en,
	input wire logic i_perso_secure,
	input wire logic i_nvm_done,
	input wire logic o_nvm_req,
	input wire logic o_nvm_to_buf,
	input wire logic o_ready,
	input wire logic o_nak,
	input wire logic o_auth_active,
	input wire logic o_enc_active,
	input wire logic o_pw_cipher,
	input wire logic o_data_cipher,
	input wire logic o_cfg_open,
	input wire logic o_perso_cipher
);
	// ****************************************
	// Session and write checks
	// ****************************************
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	logic take; // Command accepted on this edge
	logic wr_take; // Write accepted on this edge
	assign take = i_cmd_valid && o_ready;
	assign wr_take = take && i_cmd_op == CMD_WRITE;
	pw_cipher_a: assert property (o_pw_cipher == o_auth_active)
		else $error("password cipher out of step");
	data_cipher_a: assert property (o_data_cipher == o_enc_active)
		else $error("data cipher out of step");
	enc_auth_a: assert property (o_enc_active |-> o_auth_active)
		else $error("encryption without auth");
	perso_cipher_a: assert property (o_perso_cipher == (o_cfg_open && i_perso_secure && o_enc_active))
		else $error("perso cipher wrong");
	tear_len_a: assert property (wr_take && i_tear_en && i_cmd_len > TEAR_PAGE_MAX |=> o_nak && !o_nvm_req)
		else $error("long tear write taken");
	buf_first_a: assert property (wr_take && i_tear_en |=> !o_nvm_req || o_nvm_to_buf)
		else $error("tear write skipped buffer");
	copy_next_a: assert property (o_nvm_req && o_nvm_to_buf && i_nvm_done |=> o_nvm_req && !o_nvm_to_buf)
		else $error("no copy after buffer");
	req_hold_a: assert property (o_nvm_req && !i_nvm_done |=> o_nvm_req && $stable(o_nvm_to_buf) && !o_ready)
		else $error("nvm cycle dropped");
	enc_zone_a: assert property (take && i_cmd_op < 3'h2 && !i_cmd_cfg && i_zone_need_enc[i_cmd_zone]
		&& !o_enc_active |=> o_nak)
		else $error("keyed zone open in plain");
	auth_fail_a: assert property (take && i_cmd_op == CMD_AUTH && !i_auth_ok |=> !o_auth_active)
		else $error("failed auth kept");
	enc_fail_a: assert property (take && i_cmd_op == CMD_ENC && !i_auth_ok |=> !o_enc_active)
		else $error("failed activation kept");
	// Only a frame with a sound checksum counts as a valid deselect
	deselect_clear_a: assert property (take && (i_cmd_op == CMD_DESEL || i_cmd_op == CMD_IDLE)
		&& !(i_mac_present && !i_mac_ok)
		|=> !o_auth_active && !o_enc_active && !o_cfg_open)
		else $error("session kept after deselect");
	mac_bad_a: assert property (take && i_mac_present && !i_mac_ok && o_auth_active |=> o_nak && !o_auth_active)
		else $error("mac mismatch not handled");
	cover property (wr_take && i_tear_en);
	cover property ($rose(o_enc_active));
	cover property (o_nvm_req && !o_nvm_to_buf && !o_ready);
	cover property (wr_take && o_auth_active && !i_mac_present);
endmodule : sec_access_state_checker
bind sec_access_state sec_access_state_checker sec_access_state_checker_inst (.*);
`default_nettype wire

// ### verification/nvm_model.sv
// Behavioural nonvolatile memory that finishes each write cycle late
`default_nettype none
module nvm_model #(
	parameter int DLY = 3
) (
	input wire logic i_mclk,
	input wire logic i_nvm_req,
	output logic o_nvm_done
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0; // Cycles into current write
	logic done_q = 1'h0; // One-cycle completion pulse
	assign o_nvm_done = done_q;
	// Restart count for each cycle, pulse after DLY
	always @(posedge i_mclk) begin
		if (!i_nvm_req || done_q) begin
			cnt <= 0;
			done_q <= 1'h0;
		end else begin
			cnt <= cnt + 1;
			done_q <= (cnt == DLY);
		end
	end
endmodule : nvm_model
`default_nettype wire

// ### verification/sec_access_state_tb.sv
// Self-checking bench for the secure memory access state block
`default_nettype none
module sec_access_state_tb
	import sec_access_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk = 0, i_rst_b = 0, i_cmd_valid = 0, i_cmd_cfg = 0, i_cmd_pw_wr = 0, i_auth_ok = 0;
	logic i_mac_present = 0, i_mac_ok = 0, i_tear_en = 0, i_perso_secure = 1, i_tear_pending = 0, i_nvm_done;
	logic [2:0] i_cmd_op = 0;
	logic [1:0] i_cmd_zone = 0, i_cmd_set = 0, ans;
	logic [23:0] i_cmd_pw = 0, i_pw_ref = 24'h12_3456;
	logic [7:0] i_cmd_len = 8'h08, i_zone_set = 8'h00;
	logic [3:0] i_zone_need_enc = 4'h8, i_zone_need_rpw = 4'h0;
	logic o_nvm_req, o_nvm_to_buf, o_wr_cfg, o_ready, o_ack, o_nak, o_auth_active, o_enc_active;
	logic o_pw_cipher, o_data_cipher, o_cfg_open, o_perso_cipher;
	logic [1:0] o_wr_zone;
	int miscompares = 0, check_count = 0;
	initial begin
		forever #2.5 i_mclk = ~i_mclk;
	end
	sec_access_state sec_access_state_inst (.i_zone_need_wpw(4'h0), .i_zone_need_auth(4'h0), .*);
	nvm_model #(.DLY(3)) nvm_model_inst (.i_mclk(i_mclk), .i_nvm_req(o_nvm_req), .o_nvm_done(i_nvm_done));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string what, input logic [2:0] seen, input logic [2:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop
	// One strobe, answer captured, one idle cycle
	task automatic cmd(input logic [2:0] op);
		i_cmd_op = op;
		i_cmd_valid = 1'h1;
		@(negedge i_mclk);
		i_cmd_valid = 1'h0;
		ans = {o_ack, o_nak};
		@(negedge i_mclk);
	endtask : cmd
	task automatic do_reset(input logic pend);
		i_rst_b = 1'h0;
		i_tear_pending = pend;
		repeat (20) @(negedge i_mclk);
		i_rst_b = 1'h1;
		for (int i = 0; i < 60 && o_ready !== 1'h1 && o_nvm_req !== 1'h1; i++) begin
			@(negedge i_mclk);
		end
		chk("power up", {o_ready, o_nvm_req, o_nvm_to_buf}, {!pend, pend, 1'h0});
		for (int i = 0; i < 60 && o_ready !== 1'h1; i++) begin
			@(negedge i_mclk);
		end
		i_tear_pending = 1'h0;
		chk("session clear", {o_auth_active, o_enc_active, o_cfg_open}, 3'h0);
	endtask : do_reset
	// ****************************************
	// Scenarios
	// ****************************************
	// Zone 0 read needs a password; write password must open it
	task automatic s_creds();
		i_zone_need_rpw = 4'h1;
		for (int k = 0; k < 3; k++) begin
			i_cmd_cfg = 1'h1;
			i_cmd_pw = TRANSPORT_PW;
			cmd(CMD_CHKPW);
			chk("transport", {ans, o_cfg_open}, 3'h5);
			i_cmd_cfg = 1'h0;
			i_cmd_pw_wr = 1'h1;
			i_cmd_pw = i_pw_ref;
			cmd(k == 0 ? CMD_CHKPW : (k == 1 ? CMD_DESEL : CMD_IDLE));
			chk("credential drop", {ans, o_cfg_open}, 3'h4);
			cmd(CMD_READ);
			chk("password read", {1'h0, ans}, k == 0 ? 3'h2 : 3'h1);
		end
		i_zone_need_rpw = 4'h0;
	endtask : s_creds
	// Misses lock one password slot, others stay usable
	task automatic s_lock();
		i_cmd_set = 2'h1;
		i_cmd_pw_wr = 1'h0;
		i_cmd_pw = 24'h00_0001;
		repeat (ATT_LIMIT) cmd(CMD_CHKPW);
		i_cmd_pw = i_pw_ref;
		cmd(CMD_CHKPW);
		chk("locked slot", {1'h0, ans}, 3'h1);
		i_cmd_set = 2'h0;
		i_cmd_pw_wr = 1'h1;
		cmd(CMD_CHKPW);
		chk("other slot", {1'h0, ans}, 3'h2);
	endtask : s_lock
	task automatic s_auth();
		i_auth_ok = 1'h1;
		i_cmd_zone = 2'h3;
		cmd(CMD_AUTH);
		chk("auth ok", {ans, o_pw_cipher}, 3'h5);
		cmd(CMD_READ);
		chk("keyed zone plain", {ans, o_data_cipher}, 3'h2);
		cmd(CMD_ENC);
		cmd(CMD_READ);
		chk("keyed zone enc", {ans, o_data_cipher}, 3'h5);
		i_cmd_cfg = 1'h1;
		i_cmd_pw = TRANSPORT_PW;
		cmd(CMD_CHKPW);
		chk("secure perso", {o_perso_cipher, o_cfg_open, o_enc_active}, 3'h7);
		i_cmd_cfg = 1'h0;
		cmd(CMD_IDLE);
		chk("idle clears", {o_auth_active, o_enc_active, o_cfg_open}, 3'h0);
		cmd(CMD_AUTH);
		cmd(CMD_ENC);
		i_auth_ok = 1'h0;
		cmd(CMD_ENC);
		chk("enc fail", {o_auth_active, o_enc_active, o_data_cipher}, 3'h4);
		cmd(CMD_AUTH);
		chk("auth fail", {ans, o_auth_active}, 3'h2);
		i_cmd_zone = 2'h0;
	endtask : s_auth
	// Signed write passes, unsigned write and bad code drop crypto mode
	task automatic s_mac();
		int n;
		cmd(CMD_READ);
		chk("plain checksum", {ans, o_auth_active}, 3'h4);
		i_auth_ok = 1'h1;
		cmd(CMD_AUTH);
		i_mac_present = 1'h1;
		i_mac_ok = 1'h1;
		wr(1'h0, 8'h04, n);
		chk("signed write", {1'h0, o_auth_active, o_ready}, 3'h3);
		i_mac_present = 1'h0;
		cmd(CMD_WRITE);
		chk("unsigned write", {ans, o_auth_active}, 3'h2);
		cmd(CMD_AUTH);
		i_mac_present = 1'h1;
		i_mac_ok = 1'h0;
		cmd(CMD_READ);
		chk("mac mismatch", {ans, o_auth_active}, 3'h2);
		i_mac_present = 1'h0;
	endtask : s_mac
	// One write; n counts cycles until its ack
	task automatic wr(input logic tear, input logic [7:0] len, output int n);
		logic big;
		big = tear && (len > TEAR_PAGE_MAX);
		n = 0;
		i_tear_en = tear;
		i_cmd_len = len;
		i_cmd_op = CMD_WRITE;
		i_cmd_valid = 1'h1;
		@(negedge i_mclk);
		i_cmd_valid = 1'h0;
		chk("write start", {o_nvm_req, o_nvm_to_buf, o_nak}, {!big, tear && !big, big});
		while (!big && n < 60 && o_ack !== 1'h1) begin
			@(negedge i_mclk);
			n++;
		end
		chk("write end", {o_ack, o_ready, o_nak}, {!big, 1'h1, big});
		@(negedge i_mclk);
	endtask : wr
	task automatic s_write();
		int n_off, n_on, n_big;
		wr(1'h0, 8'h10, n_off);
		wr(1'h1, 8'h08, n_on);
		wr(1'h1, 8'h09, n_big);
		chk("tear slower", {2'h0, n_on > n_off}, 3'h1);
		i_tear_en = 1'h0;
	endtask : s_write
	initial begin
		repeat (5000) @(posedge i_mclk);
		miscompares++;
		report_and_stop();
	end
	initial begin
		do_reset(1'h0);
		s_creds();
		s_lock();
		s_auth();
		s_mac();
		s_write();
		// Leave live session state for the power-up to clear
		i_cmd_pw = TRANSPORT_PW;
		cmd(CMD_CHKPW);
		cmd(CMD_AUTH);
		chk("session set", {o_auth_active, o_enc_active, o_cfg_open}, 3'h5);
		do_reset(1'h1);
		report_and_stop();
	end
endmodule : sec_access_state_tb
`default_nettype wire
